// File: rtl/serial_current_loop_port.v
// Functional notes
// R1: mode 3 sends space, else mark
// R2: line level at flag bit 6, space=1
// R3: start seen, wait half, sample each bit
// R4: eight bits into accumulator low byte
// R5: line updated once each bit interval
// R6: start bit sent by setting mode 3
// R7: send stays busy eleven bit intervals
// R8: bit7 set loads bits 6:4 as mode
// R9: spare option gates input one command time
// R10: program issues gate command before testing
// R11: receive completes after full character
// R12: receive started before start bit
// R13: send shifts out accumulator low byte
// R14: low byte reads ones during send
// R15: data least significant bit first
// R16: bit timing from parameterised clock counter
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "serial_loop_regs.vh"
`default_nettype none
module serial_current_loop_port #(
  parameter        SPARE_OPT   = 1,
  parameter [21:0] HALF_CYCLES = `HALF_BIT_CYCLES,
  parameter [21:0] BIT_CYCLES  = `BIT_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        line_rx,
  output reg         line_tx
);
  localparam RX_IDLE = 2'h0;
  localparam RX_WAIT = 2'h1;
  localparam RX_SAMP = 2'h2;
  localparam RX_STOP = 2'h3;
  localparam TX_IDLE = 1'b0;
  localparam TX_RUN  = 1'b1;

  reg [2:0]  mode_q;
  reg [15:0] accum_q;
  reg [1:0]  rx_state_q;
  reg [3:0]  rx_cnt_q;
  reg [7:0]  rx_shift_q;
  reg        rx_done_q;
  reg        tx_state_q;
  reg [3:0]  tx_cnt_q;
  reg [9:0]  tx_shift_q;
  reg        gate_q;
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        rx_start;
  reg        tx_start;
  reg        fifo_pop;
  wire       rx_tick;
  wire       tx_tick;
  wire       fifo_in_ready;
  wire [7:0] fifo_data;
  wire       fifo_valid;
  wire       rx_push;
  wire       do_write;
  wire       flag_bit;

  // no option: line visible always; with option only after gate command
  assign flag_bit = (SPARE_OPT == 0) ? line_rx : (line_rx & gate_q);  // see R2 see R9

  bit_timer #(.CW(22)) u_rx_timer (
    .clk          (clk),
    .reset        (reset),
    .start        (rx_start),
    .first_count  (HALF_CYCLES),
    .period_count (BIT_CYCLES),
    .tick         (rx_tick)
  );  // see R16

  bit_timer #(.CW(22)) u_tx_timer (
    .clk          (clk),
    .reset        (reset),
    .start        (tx_start),
    .first_count  (BIT_CYCLES),
    .period_count (BIT_CYCLES),
    .tick         (tx_tick)
  );  // see R16

  assign rx_push = (rx_state_q == RX_SAMP) && rx_tick && (rx_cnt_q == `RX_BITS - 1);

  // received bytes queue here; new start bits are ignored while full
  byte_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   ({~line_rx, rx_shift_q[7:1]}),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // receiver: space (line_rx=1) marks start bit
  always @(posedge clk) begin
    if (reset) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_start   <= 1'b0;
    end else begin
      rx_start <= 1'b0;
      case (rx_state_q)
        RX_IDLE: begin
          if (line_rx && fifo_in_ready) begin
            rx_start   <= 1'b1;  // see R3
            rx_state_q <= RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (rx_tick) begin
            rx_cnt_q   <= 4'h0;
            rx_state_q <= RX_SAMP;  // see R3
          end
        end
        RX_SAMP: begin
          if (rx_tick) begin
            // mark=1 data bit, lsb arrives first
            rx_shift_q <= {~line_rx, rx_shift_q[7:1]};  // see R15
            rx_cnt_q   <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == `RX_BITS - 1)
              rx_state_q <= RX_STOP;  // see R4
          end
        end
        RX_STOP: begin
          if (!line_rx)
            rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // transmitter: start(space), 8 data, two stop marks = 11 intervals
  always @(posedge clk) begin
    if (reset) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_shift_q <= 10'h3FF;
      tx_start   <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      case (tx_state_q)
        TX_IDLE: begin
          if (do_write && awaddr_q == `REG_OP && wstrb_q[0]
              && wdata_q[`OP_SEND_BIT]) begin
            tx_shift_q <= {2'b11, accum_q[7:0]};  // see R13
            tx_cnt_q   <= 4'h0;
            tx_start   <= 1'b1;
            tx_state_q <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (tx_tick) begin
            tx_cnt_q   <= tx_cnt_q + 4'h1;
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};  // see R15
            if (tx_cnt_q == `TX_INTERVALS - 1)
              tx_state_q <= TX_IDLE;  // see R7
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // mode, accumulator, gate and line output
  always @(posedge clk) begin
    if (reset) begin
      mode_q    <= `MODE_RESET;
      accum_q   <= `ACCUM_RESET;
      gate_q    <= 1'b0;
      rx_done_q <= 1'b0;
      fifo_pop  <= 1'b0;
      line_tx   <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      // gate holds for exactly the following access
      if (do_write || (s_axi_arvalid && s_axi_arready))
        gate_q <= 1'b0;
      if (do_write) begin
        case (awaddr_q)
          `REG_CTRL_CMD: begin
            if (wstrb_q[0] && wdata_q[`CMD_LOAD_BIT] && tx_state_q == TX_IDLE)
              mode_q <= wdata_q[`CMD_MODE_MSB:`CMD_MODE_LSB];  // see R8
          end
          `REG_ACCUM: begin
            if (tx_state_q == TX_IDLE) begin
              if (wstrb_q[0])
                accum_q[7:0] <= wdata_q[7:0];
              if (wstrb_q[1])
                accum_q[15:8] <= wdata_q[15:8];
            end
          end
          `REG_OP: begin
            if (wstrb_q[0] && wdata_q[`OP_GATE_BIT])
              gate_q <= 1'b1;  // see R9
            if (wstrb_q[0] && wdata_q[`OP_RECV_BIT])
              rx_done_q <= 1'b0;  // see R12
          end
          default: ;
        endcase
      end
      if (tx_start)
        accum_q[7:0] <= 8'hFF;  // see R14
      // start bit spans the first interval only; each tick shows the next element
      if (tx_state_q == TX_RUN && tx_tick)
        mode_q <= tx_shift_q[0] ? `MODE_RESET : `MODE_SPACE;  // see R5
      if (tx_start)
        mode_q <= `MODE_SPACE;  // see R6
      // a completed character moves into the accumulator low byte
      if (fifo_valid && !fifo_pop && tx_state_q == TX_IDLE && !tx_start) begin
        accum_q[7:0] <= fifo_data;  // see R4 see R11
        rx_done_q    <= 1'b1;  // see R11
        fifo_pop     <= 1'b1;
      end
      // line current on (mark=1) except in mode 3
      line_tx <= (mode_q != `MODE_SPACE);  // see R1
    end
  end

  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // axi4-lite write: address and data taken independently
  always @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == `REG_CTRL_CMD || awaddr_q == `REG_ACCUM
                         || awaddr_q == `REG_OP) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
    end
  end

  // axi4-lite read
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        s_axi_rdata  <= 32'h00000000;
        case (s_axi_araddr)
          `REG_CTRL_CMD: s_axi_rdata[`CMD_MODE_MSB:`CMD_MODE_LSB] <= mode_q;
          `REG_FLAGS:    s_axi_rdata[`FLAG_LINE_BIT] <= flag_bit;  // see R2
          `REG_ACCUM:    s_axi_rdata[15:0] <= accum_q;
          `REG_OP:       ;
          `REG_STATUS: begin
            s_axi_rdata[`STAT_RX_BUSY]   <= (rx_state_q != RX_IDLE);
            s_axi_rdata[`STAT_TX_BUSY]   <= (tx_state_q == TX_RUN);  // see R7
            s_axi_rdata[`STAT_RX_DONE]   <= rx_done_q;
            s_axi_rdata[`STAT_SPARE_OPT] <= (SPARE_OPT != 0);
          end
          default:       s_axi_rresp <= 2'h2;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // serial_current_loop_port
`default_nettype wire

// File: rtl/serial_loop_regs.vh
`ifndef SERIAL_LOOP_REGS_VH
`define SERIAL_LOOP_REGS_VH
// register byte addresses
`define REG_CTRL_CMD      8'h00
`define REG_FLAGS         8'h04
`define REG_ACCUM         8'h08
`define REG_OP            8'h0C
`define REG_STATUS        8'h10
// control command word fields
`define CMD_LOAD_BIT      7
`define CMD_MODE_LSB      4
`define CMD_MODE_MSB      6
// flag register field
`define FLAG_LINE_BIT     6
// operation register fields
`define OP_RECV_BIT       0
`define OP_SEND_BIT       1
`define OP_GATE_BIT       2
// status register fields
`define STAT_RX_BUSY      0
`define STAT_TX_BUSY      1
`define STAT_RX_DONE      2
`define STAT_SPARE_OPT    3
// modes and reset values
`define MODE_SPACE        3'h3
`define MODE_RESET        3'h0
`define ACCUM_RESET       16'h0000
// timing, microseconds and clock
`define CLK_MHZ           250
`define HALF_BIT_US       4500
`define BIT_US            9090
`define HALF_BIT_CYCLES   (`HALF_BIT_US * `CLK_MHZ)
`define BIT_CYCLES        (`BIT_US * `CLK_MHZ)
`define TX_INTERVALS      11
`define RX_BITS           8
`endif

// File: rtl/byte_fifo.v
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  wire            take;

  // output register is not counted in cnt_q, so one more word waits outside mem
  assign take     = (cnt_q != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign pop      = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;

  always @(posedge clk) begin
    if (reset) begin
      wr_q      <= {AW{1'b0}};
      rd_q      <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_q] <= in_data;
        wr_q      <= wr_q + 1'b1;
      end
      if (take) begin
        out_data <= mem[rd_q];
        rd_q     <= rd_q + 1'b1;
      end
      if (take)
        out_valid <= 1'b1;
      else if (pop)
        out_valid <= 1'b0;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
    end
  end
endmodule // byte_fifo
`default_nettype wire

// File: rtl/bit_timer.v
`timescale 1ns/1ps
`default_nettype none
module bit_timer #(
  parameter CW = 22
) (
  input  wire          clk,
  input  wire          reset,
  input  wire          start,
  input  wire [CW-1:0] first_count,
  input  wire [CW-1:0] period_count,
  output reg           tick
);
  reg [CW-1:0] cnt_q;
  reg          run_q;

  always @(posedge clk) begin
    if (reset) begin
      cnt_q <= {CW{1'b0}};
      run_q <= 1'b0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (start) begin
        cnt_q <= first_count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {{(CW-1){1'b0}}, 1'b1}) begin
          tick  <= 1'b1;
          cnt_q <= period_count;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule // bit_timer
`default_nettype wire

// File: bench/serial_loop_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module serial_loop_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [7:0] ar_q;
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("no read response");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_no_aw_pending: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  a_read_code: assert property (s_axi_rvalid |->
    s_axi_rresp == (ar_q > 8'h10 ? 2'h2 : 2'h0)) else $error("wrong read response");
  a_op_reads_zero: assert property (s_axi_rvalid && ar_q == 8'h0C |-> s_axi_rdata == 32'h0)
    else $error("op register not zero");
endmodule // serial_loop_asserts
`default_nettype wire

// File: bench/loop_terminal.sv
`timescale 1ns/1ps
`default_nettype none
module loop_terminal #(
  parameter int BIT   = 40,
  parameter int START = 10
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       line_tx,
  output var  logic       line_rx,
  output var  logic [7:0] got,
  output var  int         got_cnt
);
  logic seen_mark;
  // full start interval: the receiver waits for its centre, then samples each data bit's
  task automatic send_char(input logic [7:0] b);
    line_rx <= 1'b1;
    repeat (START) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      line_rx <= ~b[i];
      repeat (BIT) @(posedge clk);
    end
    line_rx <= 1'b0;
    repeat (2 * BIT) @(posedge clk);
  endtask
  initial begin
    line_rx = 1'b0;
    got = 8'h00;
    got_cnt = 0;
    seen_mark = 1'b0;
    forever begin
      @(posedge clk);
      // needs a mark first, so the space held in reset is no frame
      if (!reset && seen_mark && !line_tx) begin
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge clk);
          got[i] = line_tx;
        end
        repeat (BIT) @(posedge clk);
        if (line_tx) got_cnt++;
      end
      seen_mark = line_tx && !reset;
    end
  end
endmodule // loop_terminal
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_loop_regs.vh"
module tb;
  localparam int BIT = 40;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, line_rx, line_tx;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  got;
  int          got_cnt;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h0000D2D1;
  logic [31:0] rd_v;
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  serial_current_loop_port #(.HALF_CYCLES(22'd20), .BIT_CYCLES(22'd40)) dut (
    .clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_rx(line_rx), .line_tx(line_tx));
  loop_terminal #(.BIT(BIT), .START(BIT)) term (.clk(clk), .reset(reset),
    .line_tx(line_tx), .line_rx(line_rx), .got(got), .got_cnt(got_cnt));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] sending_accum(input logic [15:0] v);
    return {16'h0, v[15:8], 8'hFF};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ready comes 0..2 cycles late, yet is up before the response arrives
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n, dly;
    @(posedge clk);
    n = 0;
    dly = rnd() % 3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (dly == 0);
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= !(bvalid && bready) && n >= dly;
    end while (!(bvalid && bready) && n < 100);
    chk({31'h0, bvalid && bready}, 32'h1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n, dly;
    @(posedge clk);
    n = 0;
    dly = rnd() % 3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (dly == 0);
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      rready <= !(rvalid && rready) && n >= dly;
    end while (!(rvalid && rready) && n < 100);
    chk({31'h0, rvalid && rready}, 32'h1);
    rd_v = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, 2'h0);
    chk(rd_v, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] rv;
    logic [15:0] v;
    logic [7:0]  b;
    int          t0, n;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, line_tx}, 32'h1);
    rdc(`REG_STATUS, 32'h8);
    rdc(`REG_ACCUM, 32'h0);
    rdc(`REG_OP, 32'h0);
    rd(8'h14, 2'h2);
    wr(8'h20, 32'h0, 2'h2);
    for (int m = 0; m < 8; m++) begin
      wr(`REG_CTRL_CMD, {24'h0, 1'b1, m[2:0], 4'h0}, 2'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, line_tx}, {31'h0, m[2:0] != `MODE_SPACE});
      rdc(`REG_CTRL_CMD, {25'h0, m[2:0], 4'h0});
    end
    wr(`REG_CTRL_CMD, 32'h30, 2'h0);
    rdc(`REG_CTRL_CMD, 32'h70);
    wr(`REG_CTRL_CMD, 32'h80, 2'h0);
    for (int l = 0; l < 2; l++) begin
      term.line_rx <= l[0];
      wr(`REG_OP, 32'h4, 2'h0);
      rdc(`REG_FLAGS, {25'h0, l[0], 6'h0});
      rdc(`REG_FLAGS, 32'h0);
    end
    term.line_rx <= 1'b0;
    repeat (400) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      rv = rnd();
      b = (k == 0) ? 8'h01 : (k == 1) ? 8'hFE : rv[7:0];
      wr(`REG_OP, 32'h1, 2'h0);
      term.send_char(b);
      rd(`REG_STATUS, 2'h0);
      chk(rd_v & 32'h4, 32'h4);
      rdc(`REG_ACCUM, {24'h0, b});
    end
    // lane 0 only: the high byte must keep its value
    wstrb <= 4'h1;
    wr(`REG_ACCUM, 32'h0000BEEF, 2'h0);
    wstrb <= 4'hF;
    rdc(`REG_ACCUM, 32'h000000EF);
    for (int k = 0; k < 3; k++) begin
      rv = rnd();
      v = (k == 0) ? 16'h5500 : (k == 1) ? 16'hA5FF : rv[15:0];
      n = got_cnt;
      wr(`REG_ACCUM, {16'h0, v}, 2'h0);
      wr(`REG_OP, 32'h2, 2'h0);
      t0 = cyc;
      rdc(`REG_CTRL_CMD, 32'h30);
      rdc(`REG_ACCUM, sending_accum(v));
      wr(`REG_ACCUM, 32'h1234, 2'h0);
      wr(`REG_OP, 32'h2, 2'h0);
      rdc(`REG_ACCUM, sending_accum(v));
      rd(`REG_STATUS, 2'h0);
      chk(rd_v & 32'h2, 32'h2);
      while (rd_v[1] && cyc - t0 < 1000) rd(`REG_STATUS, 2'h0);
      chk({31'h0, cyc - t0 >= 11 * BIT - 4 && cyc - t0 <= 11 * BIT + 12}, 32'h1);
      chk({24'h0, got}, {24'h0, v[7:0]});
      chk(got_cnt, n + 1);
    end
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule // tb
bind serial_current_loop_port serial_loop_asserts chk_i (.clk(clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
